// >>> core/link_err_pkg.sv
package link_err_pkg;

  typedef enum logic [2:0] {
    REACT_NONE,
    REACT_RAMP_STOP,
    REACT_DISABLE,
    REACT_LOCAL,
    REACT_LOCAL_HOLD,
    REACT_FAULT
  } react_t;

  // Five link error sources, in alarm/fault order.
  typedef struct packed {
    logic io_timeout;
    logic master_idle;
    logic guarding_loss;
    logic bus_off;
    logic unpowered;
  } link_err_t;

  // Drive state feeding the status word.
  typedef struct packed {
    logic run_cmd;
    logic fire_mode;
    logic ramp2;
    logic config_mode;
    logic running;
    logic enabled;
    logic forward;
    logic inching_active;
    logic undervoltage;
  } drive_state_t;

  typedef enum logic [1:0] {
    RATE_125K,
    RATE_250K,
    RATE_500K
  } bit_rate_t;

endpackage

// >>> core/link_err_regs.svh
`ifndef LINK_ERR_REGS_SVH
`define LINK_ERR_REGS_SVH

// Register byte addresses on the Wishbone slave.
`define ADDR_REACT_SEL 8'h00
`define ADDR_STATUS_WORD 8'h04
`define ADDR_LINK_CFG 8'h08
`define ADDR_ERR_FLAGS 8'h0C
`define ADDR_CTRL_WORD 8'h10
`define ADDR_LOCAL_CTRL 8'h14

// Reset values.
`define RST_REACT_SEL 16'h0001
`define RST_NODE_ADDR 6'h3F
`define RST_BIT_RATE 2'h0

// Reaction code limit.
`define REACT_MAX 3'h5

// Status word bit positions.
`define SW_RUN_CMD 1
`define SW_FIRE 2
`define SW_RAMP2 5
`define SW_CONFIG 6
`define SW_ALARM 7
`define SW_RUNNING 8
`define SW_ENABLED 9
`define SW_FORWARD 10
`define SW_JOG 11
`define SW_REMOTE 12
`define SW_UNDERVOLT 13
`define SW_FAULT 15

// Control word bit positions.
`define CW_RAMP_EN 0
`define CW_GEN_EN 1
`define CW_REMOTE 4
`define CW_FAULT_RST 7

// Link configuration fields.
`define LC_ADDR_LSB 0
`define LC_RATE_LSB 8

`endif

// >>> core/link_error_action_status.sv
// Overview of operation
// - Reaction select holds codes 0..5, resets to 1, acts only under network control except code 5.
// - Five link error sources, each with its own alarm and fault flag.
// - Reaction is applied by writing bits of the network control word.
// - Control word acts only under network control; fault reaction blocks always. Its fault reset bit 7 clears a latched fault without network control too.
// - Code 0 takes no action; drive state is unchanged.
// - Code 1 clears ramp enable so the motor ramps down.
// - Code 2 clears general enable so the motor coasts.
// - Code 3 switches the command source to local.
// - Code 4 goes local keeping last network enable and speed reference.
// - Code 5 raises a latched drive fault cleared only by fault reset.
// - Node address 0..63, unique on the network.
// - All nodes use the same bit rate: 125, 250 or 500 kbit/s.
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "link_err_regs.svh"

module link_error_action_status
  import link_err_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Link supervisor inputs.
  input wire link_err_t link_err_i,
  input wire logic net_control_i,
  input wire logic local_hold_allowed_i,
  input wire drive_state_t drive_state_i,
  input wire logic fault_reset_i,
  // Drive command outputs.
  output logic [15:0] ctrl_word_o,
  output logic switch_to_local_o,
  output logic switch_local_hold_commands_o,
  output logic drive_block_o,
  output link_err_t alarm_o,
  output link_err_t fault_o,
  output logic [15:0] logical_status_word_o,
  output logic [5:0] node_address_o,
  output bit_rate_t bit_rate_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus.

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [31:0] dat,
                                           input logic [3:0] sel);
    logic [15:0] v;
    v = old_v;
    if (sel[0]) begin
      v[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      v[15:8] = dat[15:8];
    end
    return v;
  endfunction

  // A request is taken only while no ack is out. A master that holds its strobe
  // past the ack is therefore served every other cycle and never twice by mistake.
  function automatic logic bus_take(input logic cyc,
                                    input logic stb,
                                    input logic ack);
    return cyc && stb && !ack;
  endfunction

  // One place decides what each address reads back. Holes in the map and the
  // upper half of every word read as zero, so software can probe safely.
  function automatic logic [31:0] read_mux(input logic [7:0] adr,
                                           input logic [15:0] sel_v,
                                           input logic [15:0] stat_v,
                                           input logic [9:0] cfg_v,
                                           input logic [9:0] flag_v,
                                           input logic [15:0] ctrl_v,
                                           input logic [15:0] host_v);
    logic [31:0] r;
    r = 32'h00000000;
    case (adr)
      `ADDR_REACT_SEL: r = {16'h0000, sel_v};
      `ADDR_STATUS_WORD: r = {16'h0000, stat_v};
      `ADDR_LINK_CFG: r = {22'h000000, cfg_v};
      `ADDR_ERR_FLAGS: r = {22'h000000, flag_v};
      `ADDR_CTRL_WORD: r = {16'h0000, ctrl_v};
      `ADDR_LOCAL_CTRL: r = {16'h0000, host_v};
      default: r = 32'h00000000;
    endcase
    return r;
  endfunction

  logic [15:0] react_sel_r, react_sel_nxt;
  logic [15:0] host_ctrl_r, host_ctrl_nxt;
  logic [5:0] node_addr_r, node_addr_nxt;
  bit_rate_t rate_r, rate_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic [15:0] status_r, status_nxt;
  logic [15:0] ctrl_r, ctrl_nxt;
  logic fault_latch_r, fault_latch_nxt;
  link_err_t fault_src_r, fault_src_nxt;
  link_err_t alarm_r, alarm_nxt;
  logic local_r, local_nxt;
  logic hold_r, hold_nxt;
  logic block_r, block_nxt;

  logic wr_req;
  logic any_err;
  logic [15:0] merged;
  logic [2:0] rate_wr;
  react_t react;

  assign wr_req = bus_take(wb_cyc_i, wb_stb_i, ack_r) && wb_we_i;
  assign any_err = |link_err_i;
  assign react = react_t'(react_sel_r[2:0]);

  always_comb begin
    react_sel_nxt = react_sel_r;
    host_ctrl_nxt = host_ctrl_r;
    node_addr_nxt = node_addr_r;
    rate_nxt = rate_r;
    // Ack is registered, so it always follows the taking edge by exactly one cycle.
    ack_nxt = bus_take(wb_cyc_i, wb_stb_i, ack_r);
    rdat_nxt = rdat_r;
    merged = 16'h0000;
    rate_wr = 3'h0;
    if (wr_req) begin
      case (wb_adr_i)
        `ADDR_REACT_SEL: begin
          merged = merge16(react_sel_r, wb_dat_i, wb_sel_i);
          // Out-of-range codes are ignored so the setting always stays valid.
          if (merged <= {13'h0000, `REACT_MAX}) begin
            react_sel_nxt = merged;
          end
        end
        `ADDR_LINK_CFG: begin
          if (wb_sel_i[0]) begin
            node_addr_nxt = wb_dat_i[`LC_ADDR_LSB +: 6];
          end
          rate_wr = {1'b0, wb_dat_i[`LC_RATE_LSB +: 2]};
          if (wb_sel_i[1] && rate_wr <= 3'h2) begin
            rate_nxt = bit_rate_t'(rate_wr[1:0]);
          end
        end
        `ADDR_LOCAL_CTRL: begin
          host_ctrl_nxt = merge16(host_ctrl_r, wb_dat_i, wb_sel_i);
        end
        default: begin
        end
      endcase
    end
    // Read data is held between reads so a slow master still sees it with the ack.
    if (bus_take(wb_cyc_i, wb_stb_i, ack_r) && !wb_we_i) begin
      rdat_nxt = read_mux(wb_adr_i, react_sel_r, status_r,
                          {rate_r, 2'h0, node_addr_r},
                          {fault_src_r, alarm_r},
                          ctrl_r, host_ctrl_r);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      react_sel_r <= `RST_REACT_SEL;
      host_ctrl_r <= 16'h0000;
      node_addr_r <= `RST_NODE_ADDR;
      rate_r <= RATE_125K;
      ack_r <= 1'b0;
      rdat_r <= 32'h00000000;
    end else begin
      react_sel_r <= react_sel_nxt;
      host_ctrl_r <= host_ctrl_nxt;
      node_addr_r <= node_addr_nxt;
      rate_r <= rate_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link error reaction.

  // The word the network wrote passes through unchanged unless a reaction is due.
  // Reactions only ever clear bits, so a link error can never start the motor.
  always_comb begin
    ctrl_nxt = host_ctrl_r;
    fault_latch_nxt = fault_latch_r;
    fault_src_nxt = fault_src_r;
    alarm_nxt = 5'h00;
    local_nxt = 1'b0;
    hold_nxt = 1'b0;
    // Fault reset is weaker than a fresh error: a still-active link error re-latches.
    if (fault_reset_i || host_ctrl_r[`CW_FAULT_RST]) begin
      fault_latch_nxt = 1'b0;
      fault_src_nxt = 5'h00;
    end
    if (any_err) begin
      case (react)
        REACT_NONE: begin
        end
        REACT_RAMP_STOP: begin
          if (net_control_i) begin
            ctrl_nxt[`CW_RAMP_EN] = 1'b0;
          end
        end
        REACT_DISABLE: begin
          if (net_control_i) begin
            ctrl_nxt[`CW_GEN_EN] = 1'b0;
          end
        end
        REACT_LOCAL: begin
          if (net_control_i) begin
            ctrl_nxt[`CW_REMOTE] = 1'b0;
            local_nxt = 1'b1;
          end
        end
        REACT_LOCAL_HOLD: begin
          if (net_control_i) begin
            // Enable and speed bits stay as last received; only the source moves.
            ctrl_nxt[`CW_REMOTE] = 1'b0;
            local_nxt = 1'b1;
            hold_nxt = local_hold_allowed_i;
          end
        end
        REACT_FAULT: begin
          fault_latch_nxt = 1'b1;
          fault_src_nxt = fault_src_r | link_err_i;
        end
        default: begin
        end
      endcase
      if (react != REACT_FAULT) begin
        alarm_nxt = link_err_i;
      end
    end
    if (fault_latch_nxt) begin
      // A latched fault disables the drive whatever the command source.
      ctrl_nxt[`CW_GEN_EN] = 1'b0;
      ctrl_nxt[`CW_RAMP_EN] = 1'b0;
    end
    block_nxt = fault_latch_nxt;
    status_nxt = 16'h0000;
    status_nxt[`SW_RUN_CMD] = drive_state_i.run_cmd;
    status_nxt[`SW_FIRE] = drive_state_i.fire_mode;
    status_nxt[`SW_RAMP2] = drive_state_i.ramp2;
    status_nxt[`SW_CONFIG] = drive_state_i.config_mode;
    status_nxt[`SW_ALARM] = |alarm_nxt;
    status_nxt[`SW_RUNNING] = drive_state_i.running;
    status_nxt[`SW_ENABLED] = drive_state_i.enabled;
    status_nxt[`SW_FORWARD] = drive_state_i.forward;
    status_nxt[`SW_JOG] = drive_state_i.inching_active;
    status_nxt[`SW_REMOTE] = ctrl_nxt[`CW_REMOTE] && !local_nxt;
    status_nxt[`SW_UNDERVOLT] = drive_state_i.undervoltage;
    status_nxt[`SW_FAULT] = fault_latch_nxt;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= 16'h0000;
      fault_latch_r <= 1'b0;
      fault_src_r <= 5'h00;
      alarm_r <= 5'h00;
      local_r <= 1'b0;
      hold_r <= 1'b0;
      block_r <= 1'b0;
      status_r <= 16'h0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      fault_latch_r <= fault_latch_nxt;
      fault_src_r <= fault_src_nxt;
      alarm_r <= alarm_nxt;
      local_r <= local_nxt;
      hold_r <= hold_nxt;
      block_r <= block_nxt;
      status_r <= status_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign ctrl_word_o = ctrl_r;
  assign switch_to_local_o = local_r;
  assign switch_local_hold_commands_o = hold_r;
  assign drive_block_o = block_r;
  assign alarm_o = alarm_r;
  assign fault_o = fault_src_r;
  assign logical_status_word_o = status_r;
  assign node_address_o = node_addr_r;
  assign bit_rate_o = rate_r;

endmodule
`default_nettype wire

// >>> tb/link_error_action_status_chk.sv
`timescale 1ns/1ps
`default_nettype none
module link_error_action_status_chk
  import link_err_pkg::*;
(
  // Watched ports.
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire link_err_t link_err_i,
  input wire drive_state_t drive_state_i,
  input wire logic [15:0] ctrl_word_o,
  input wire logic switch_to_local_o,
  input wire logic switch_local_hold_commands_o,
  input wire logic drive_block_o,
  input wire link_err_t alarm_o,
  input wire logic [15:0] logical_status_word_o,
  input wire bit_rate_t bit_rate_o
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_once: assert property (s_req |=> s_ack) else $error("ack not one pulse");
  a_alarm_track: assert property (alarm_o != 5'h00 |-> alarm_o == $past(link_err_i))
    else $error("alarm not tied to error");
  a_alarm_bit: assert property (alarm_o != 5'h00 |-> logical_status_word_o[7])
    else $error("alarm bit missing");
  a_fault_bit: assert property (drive_block_o |-> logical_status_word_o[15] && alarm_o == 5'h00)
    else $error("fault bit missing");
  a_reserved_zero: assert property (logical_status_word_o[0] == 1'b0 &&
    logical_status_word_o[4:3] == 2'h0 && logical_status_word_o[14] == 1'b0)
    else $error("reserved bit set");
  a_block_ctrl: assert property (drive_block_o |-> ctrl_word_o[1:0] == 2'h0)
    else $error("enables not cleared");
  a_running_copy: assert property (logical_status_word_o[8] == $past(drive_state_i.running))
    else $error("running bit wrong");
  a_hold_local: assert property (switch_local_hold_commands_o |-> switch_to_local_o)
    else $error("hold without local");
  a_rate_legal: assert property (bit_rate_o != 2'h3) else $error("bad rate");
endmodule
bind link_error_action_status link_error_action_status_chk u_chk (.clk_sys, .rst_b,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .link_err_i, .drive_state_i, .ctrl_word_o,
  .switch_to_local_o, .switch_local_hold_commands_o, .drive_block_o, .alarm_o,
  .logical_status_word_o, .bit_rate_o);
`default_nettype wire

// >>> tb/link_error_action_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module link_error_action_status_tb;
  import link_err_pkg::*;
  logic clk_sys = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, hold_ok = 1, frst = 0, ctl_req = 1;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, dat_o, q;
  logic ack, nctl, to_loc, hold, blk;
  link_err_t err_req = '0, lerr, alarm, fault, src;
  drive_state_t dstate = '0;
  logic [15:0] cw, sw;
  logic [5:0] naddr;
  bit_rate_t rate;
  int n_errors = 0, checks_done = 0;
  logic [15:0] cwe [6] = '{16'h0013, 16'h0012, 16'h0011, 16'h0013, 16'h0013, 16'h0010};
  logic [15:0] cwm [6] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000, 16'hFFFF};
  logic [2:0] lce [6] = '{3'h0, 3'h0, 3'h0, 3'h4, 3'h6, 3'h1};
  int pos [9] = '{13, 11, 10, 9, 8, 6, 5, 2, 1};
  link_error_action_status dut (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .link_err_i(lerr), .net_control_i(nctl),
    .local_hold_allowed_i(hold_ok), .drive_state_i(dstate), .fault_reset_i(frst),
    .ctrl_word_o(cw), .switch_to_local_o(to_loc), .switch_local_hold_commands_o(hold),
    .drive_block_o(blk), .alarm_o(alarm), .fault_o(fault), .logical_status_word_o(sw),
    .node_address_o(naddr), .bit_rate_o(rate));
  net_master_model peer (.clk_sys(clk_sys), .rst_b(rst_b), .err_req(err_req),
    .ctl_req(ctl_req), .link_err_o(lerr), .net_control_o(nctl));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; n = 0;
    do begin @(posedge clk_sys); n++; end while (ack !== 1'b1 && n < 20);
    q = dat_o; cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk_sys);
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1;
    @(posedge clk_sys);
    bus(0, 8'h00, 0); chk("select reset", q, 32'h1);
    bus(0, 8'h08, 0); chk("cfg reset", q, 32'h3F);
    bus(1, 8'h00, 32'h6); bus(0, 8'h00, 0); chk("select over 5", q, 32'h1);
    bus(0, 8'h20, 0); chk("unmapped", q, 32'h0);
    bus(1, 8'h08, 32'h0205); chk("addr", naddr, 6'h05); chk("rate", rate, 2'h2);
    bus(1, 8'h08, 32'h0300); chk("rate 3", rate, 2'h2);
    $display("config test done");
    for (int i = 0; i < 9; i++) begin
      dstate <= drive_state_t'(9'h1 << i); repeat (2) @(posedge clk_sys);
      chk("status", sw & 16'hEFFF, 16'h1 << pos[i]);
    end
    bus(1, 8'h04, 32'h0); bus(0, 8'h04, 0); chk("status ro", q[15:0] & 16'hEFFF, 16'h0002);
    $display("status test done");
    bus(1, 8'h14, 32'h0013);
    for (int c = 0; c < 6; c++) begin
      src = link_err_t'(5'h01 << (c % 5));
      bus(1, 8'h00, c); err_req <= src; repeat (3) @(posedge clk_sys);
      chk("ctrl", cw & cwm[c], cwe[c] & cwm[c]);
      chk("local", {to_loc, hold, blk}, lce[c]);
      chk("alarm", alarm, c < 5 ? src : 5'h00);
      chk("fault", fault, c == 5 ? src : 5'h00);
      err_req <= '0; repeat (3) @(posedge clk_sys);
      chk("latched", blk, c == 5);
      frst <= 1; @(posedge clk_sys); frst <= 0; repeat (2) @(posedge clk_sys);
      chk("reset fault", blk, 1'b0);
    end
    $display("reaction test done");
    ctl_req <= 0; bus(1, 8'h00, 1); err_req <= '1; repeat (3) @(posedge clk_sys);
    chk("no net ctrl", cw, 16'h0013);
    bus(1, 8'h00, 5); repeat (2) @(posedge clk_sys);
    chk("block local", blk, 1'b1);
    $display("network control test done");
    close_out();
  end
  // The full run needs about 140 cycles; the 5000-cycle limit is over thirty times that and means a hang.
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    close_out();
  end
endmodule
`default_nettype wire

// >>> tb/net_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module net_master_model
  import link_err_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Scenario control.
  input wire link_err_t err_req,
  input wire logic ctl_req,
  // Toward the supervisor.
  output link_err_t link_err_o,
  output logic net_control_o
);
  // Link faults change only on a clock edge, as a real link monitor would report them.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      link_err_o <= '0;
      net_control_o <= 1'b0;
    end else begin
      link_err_o <= err_req;
      net_control_o <= ctl_req;
    end
  end
endmodule
`default_nettype wire
